// file: inc/soft_off_consts.svh
// constants for the soft off / power protection stage: offsets, fields, resets, counts
// assumes a 12-bit register address and byte-wide register data
`ifndef SOFT_OFF_CONSTS_SVH
`define SOFT_OFF_CONSTS_SVH

// register offsets
`define OFS_LINK_IRQ_ROUTE   12'h4BC
`define OFS_GAIN_CTRL        12'h580
`define OFS_OFF_ENABLE       12'h581
`define OFS_ON_ENABLE        12'h582
`define OFS_LONG_THR_LO      12'h583
`define OFS_LONG_THR_HI      12'h584
`define OFS_LONG_CTRL        12'h585
`define OFS_LONG_PWR_LO      12'h586
`define OFS_LONG_PWR_HI      12'h587
`define OFS_SHORT_THR_LO     12'h588
`define OFS_SHORT_THR_HI     12'h589
`define OFS_SHORT_CTRL       12'h58A
`define OFS_SHORT_PWR_LO     12'h58B
`define OFS_SHORT_PWR_HI     12'h58C

// field positions
`define BIT_LINK_IRQ_SEL     0
`define BIT_RAMP_MASTER_EN   7
`define BIT_OFF_SHORT_ERR    7
`define BIT_OFF_LONG_ERR     6
`define BIT_OFF_LINK_ERR     3
`define BIT_OFF_ROTATION     2
`define BIT_OFF_TXEN_FALL    1
`define BIT_OFF_SOFTWARE     0
`define BIT_ON_SOFTWARE      7
`define BIT_ON_LONG_LEVEL    6
`define BIT_METER_EN         7

// reset values
`define RST_OFF_ENABLE       8'hC6
`define RST_ON_ENABLE        8'h40

// ramp and meter counts
`define RAMP_STEPS           6'h20
`define RAMP_STEP_SHIFT      3
`define LONG_BASE_SHIFT      9
`define PA_MULT_MAIN         4
`define PA_MULT_CHAN         8
`define PA_PERIOD_PLAIN      9'h020
`define SAMPLE_KEEP_BITS     6

`endif

// file: inc/soft_off_pkg.sv
// types for the soft off / power protection stage
// assumes soft_off_consts.svh is compiled alongside
package soft_off_pkg;

	// gain ramp states
	typedef enum logic [1:0] {
		GAIN_UNITY = 2'b00,
		GAIN_DOWN  = 2'b01,
		GAIN_ZERO  = 2'b10,
		GAIN_UP    = 2'b11
	} gain_state_t;

	// one averaging window of the power meter
	typedef struct packed {
		logic [24:0] count;
		logic [35:0] acc;
		logic [12:0] avg;
		logic        err;
		logic        done;
	} meter_t;

	// complex sample pair
	typedef struct packed {
		logic [15:0] i;
		logic [15:0] q;
	} iq_t;

	// whole state of the stage
	typedef struct packed {
		logic [7:0]  gain_ctrl;
		logic [7:0]  off_en;
		logic [7:0]  on_en;
		logic [12:0] long_thr;
		logic [7:0]  long_ctrl;
		logic [12:0] short_thr;
		logic [7:0]  short_ctrl;
		logic        irq_sel;
		gain_state_t gstate;
		logic [5:0]  gain;
		logic [10:0] step_cnt;
		logic [8:0]  pa_cnt;
		meter_t      long_m;
		meter_t      short_m;
		logic        txen_prev;
		iq_t         out;
		logic [7:0]  rdata;
		logic        interrupt_pin_zero;
		logic        interrupt_pin_one;
	} state_t;

endpackage

// file: verif/soft_off_chk.sv
// assertions for the soft off / power protection stage, bound to its top module
// assumes soft_off_pkg and soft_off_consts.svh are compiled first; one clock domain
`timescale 1ns/1ps
`include "soft_off_consts.svh"

module soft_off_chk
	import soft_off_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_write_i,
	input  wire logic        main_path_page_select_i,
	input  wire iq_t         sample_i,
	input  wire iq_t         sample_o,
	input  wire logic [5:0]  gain_o,
	input  wire logic        link_irq_i,
	input  wire logic        interrupt_pin_zero_o,
	input  wire logic        interrupt_pin_one_o,
	input  wire logic        short_power_error_o,
	input  wire logic        long_power_error_o
);
	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	// ==========================================
	// shadow control bytes, kept from paged writes
	logic [7:0] gc_q, lc_q, sc_q;
	logic       sel_q, we;
	assign we = reg_write_i & main_path_page_select_i;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			{gc_q, lc_q, sc_q, sel_q} <= '0;
		end else if (we) begin
			if (reg_addr_i == `OFS_GAIN_CTRL) gc_q <= reg_wdata_i;
			if (reg_addr_i == `OFS_LONG_CTRL) lc_q <= reg_wdata_i;
			if (reg_addr_i == `OFS_SHORT_CTRL) sc_q <= reg_wdata_i;
			if (reg_addr_i == `OFS_LINK_IRQ_ROUTE) sel_q <= reg_wdata_i[0];
		end
	end

	// ==========================================
	// properties
	property p_irq_route;
		!reg_write_i |=> interrupt_pin_zero_o == ($past(link_irq_i) & ~sel_q)
			&& interrupt_pin_one_o == ($past(link_irq_i) & sel_q);
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("link irq pin routing wrong");
	property p_master_off;
		!gc_q[7] && !$past(gc_q[7]) |-> gain_o == 6'h20;
	endproperty
	a_master_off: assert property (p_master_off) else $error("gain moved with ramp disabled");
	// a jump to unity is allowed, since clearing the master enable forces it
	property p_step_gap;
		$changed(gain_o) && gain_o != 6'h00 && gain_o != 6'h20
			|=> (gain_o == $past(gain_o) || gain_o == 6'h20) [*7];
	endproperty
	a_step_gap: assert property (p_step_gap) else $error("gain steps too close");
	property p_ramp_len;
		gain_o == 6'h1F && $past(gain_o) == 6'h20 && gc_q[2:0] == 3'h0 |-> ##248 gain_o == 6'h00;
	endproperty
	a_ramp_len: assert property (p_ramp_len) else $error("ramp down length wrong");
	property p_sw_off;
		we && reg_addr_i == `OFS_OFF_ENABLE && reg_wdata_i[0] && gc_q == 8'h80
			&& gain_o == 6'h20 && $past(gain_o) == 6'h20 |-> ##[8:10] gain_o == 6'h1F;
	endproperty
	a_sw_off: assert property (p_sw_off) else $error("forced ramp down did not start");
	property p_sw_on;
		we && reg_addr_i == `OFS_ON_ENABLE && reg_wdata_i[7] && gc_q == 8'h80
			&& gain_o == 6'h00 && $past(gain_o) == 6'h00 |-> ##[8:10] gain_o == 6'h01;
	endproperty
	a_sw_on: assert property (p_sw_on) else $error("forced ramp up did not start");
	property p_long_off;
		!lc_q[7] && !$past(lc_q[7]) |-> !long_power_error_o;
	endproperty
	a_long_off: assert property (p_long_off) else $error("long error with meter off");
	property p_short_off;
		!sc_q[7] && !$past(sc_q[7]) |-> !short_power_error_o;
	endproperty
	a_short_off: assert property (p_short_off) else $error("short error with meter off");
	property p_scale;
		!$past(reset_i) && gain_o == $past(gain_o) && (gain_o == 6'h20 || gain_o == 6'h00)
			|-> sample_o == (gain_o == 6'h00 ? 32'h0 : $past(sample_i));
	endproperty
	a_scale: assert property (p_scale) else $error("output sample not scaled by gain");
endmodule

bind soft_off_power_protect soft_off_chk chk_i (.*);

// file: verif/tb.sv
// self-checking bench for the soft off / power protection stage
// assumes design, package, constants and checker are compiled before it
`timescale 1ns/1ps
`include "soft_off_consts.svh"

module tb;
	import soft_off_pkg::*;
	logic        mclk_i, reset_i, reg_write_i, reg_read_i, main_path_page_select_i, rd_v, rnd_on;
	logic        transmit_enable_pin_i, link_error_i, sync_rotation_i, sync_rotation_arm_i, link_irq_i;
	logic        interrupt_pin_zero_o, interrupt_pin_one_o, short_power_error_o, long_power_error_o;
	logic [11:0] reg_addr_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o, rv;
	logic [3:0]  main_interp_i, chan_interp_i;
	logic [5:0]  gain_o;
	iq_t         sample_i, sample_o;
	logic [7:0]  exp_q[$];
	int          fail_count, samples_checked;
	localparam logic [19:0] rst_t [9] = '{20'h58000, 20'h581C6, 20'h58240, 20'h58300, 20'h58400,
		20'h58500, 20'h58600, 20'h4BC00, 20'h59000};
	localparam logic [27:0] msk_t [8] = '{28'h4BCFF01, 28'h581FFCF, 28'h582FFFF, 28'h583FFFF,
		28'h584FF1F, 28'h585FF8F, 28'h5865500, 28'h580FF87};

	soft_off_power_protect DUT (.*);

	// ==========================================
	// clock, watchdog, compare and closing
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#4000000;
		fail_count++;
		end_sim();
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ==========================================
	// register port and gain helpers; strobes drop a full cycle apart to avoid double assignment
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge mclk_i);
		reg_write_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge mclk_i);
		reg_read_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic gw(input int n, input logic [5:0] e);
		repeat (n) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("gain_o", 16'(e), 16'(gain_o));
		@(posedge mclk_i);
	endtask

	// read data is judged half a cycle after the accepting edge, oldest note first
	always @(posedge mclk_i) rd_v <= reg_read_i & main_path_page_select_i;
	always @(negedge mclk_i) if (rd_v === 1'b1) chk("reg_rdata_o", 16'(exp_q.pop_front()), 16'(reg_rdata_o));
	// random samples and link irq while ramps run, so scaling and routing see real traffic
	// otherwise steady samples: top six bits 9 and -9, so each tick carries power 162
	always @(posedge mclk_i) begin
		if (rnd_on) begin
			sample_i <= iq_t'($urandom);
			link_irq_i <= 1'($urandom);
		end else begin
			sample_i <= '{16'h2400, 16'hDC00};
			link_irq_i <= 1'b1;
		end
	end

	// ==========================================
	// main sequence
	initial begin
		{reg_write_i, reg_read_i, link_error_i, sync_rotation_i, sync_rotation_arm_i} = '0;
		{reg_addr_i, reg_wdata_i, rnd_on} = '0;
		{main_path_page_select_i, transmit_enable_pin_i, reset_i} = 3'h7;
		main_interp_i = 4'h1;
		chan_interp_i = 4'h1;
		void'($urandom(32'h2a45));
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		rnd_on <= 1'b1;
		@(posedge mclk_i);
		foreach (rst_t[k]) rd(rst_t[k][19:8], rst_t[k][7:0]);
		foreach (msk_t[k]) begin
			wr(msk_t[k][27:16], msk_t[k][15:8]);
			rd(msk_t[k][27:16], msk_t[k][7:0]);
		end
		main_path_page_select_i <= 1'b0;
		wr(`OFS_LONG_THR_LO, 8'h55);
		main_path_page_select_i <= 1'b1;
		rd(`OFS_LONG_THR_LO, 8'hFF);
		rv = 8'($urandom);
		wr(`OFS_LONG_THR_LO, rv);
		rd(`OFS_LONG_THR_LO, rv);
		wr(`OFS_OFF_ENABLE, 8'hC6);
		wr(`OFS_LONG_CTRL, 8'h00);
		wr(`OFS_LINK_IRQ_ROUTE, 8'h00);
		wr(`OFS_GAIN_CTRL, 8'h80);
		wr(`OFS_OFF_ENABLE, 8'hC7);
		gw(300, 6'h00);
		wr(`OFS_OFF_ENABLE, 8'hC7);
		gw(20, 6'h00);
		wr(`OFS_ON_ENABLE, 8'hC0);
		gw(300, 6'h20);
		transmit_enable_pin_i <= 1'b0;
		gw(300, 6'h00);
		wr(`OFS_ON_ENABLE, 8'hC0);
		link_error_i <= 1'b1;
		gw(300, 6'h20);
		wr(`OFS_OFF_ENABLE, 8'hCE);
		gw(300, 6'h00);
		link_error_i <= 1'b0;
		wr(`OFS_ON_ENABLE, 8'hC0);
		sync_rotation_i <= 1'b1;
		gw(300, 6'h20);
		sync_rotation_arm_i <= 1'b1;
		gw(300, 6'h00);
		sync_rotation_i <= 1'b0;
		wr(`OFS_ON_ENABLE, 8'hC0);
		gw(300, 6'h20);
		wr(`OFS_GAIN_CTRL, 8'h00);
		wr(`OFS_OFF_ENABLE, 8'hC7);
		gw(300, 6'h20);
		wr(`OFS_GAIN_CTRL, 8'h81);
		wr(`OFS_OFF_ENABLE, 8'hC7);
		gw(280, 6'h0F);
		gw(260, 6'h00);
		wr(`OFS_ON_ENABLE, 8'hC0);
		gw(600, 6'h20);
		wr(`OFS_GAIN_CTRL, 8'h80);
		// steady samples from here; the short test is paced by channel interpolation
		rnd_on <= 1'b0;
		chan_interp_i <= 4'h2;
		@(posedge mclk_i);
		wr(`OFS_LINK_IRQ_ROUTE, 8'h01);
		@(negedge mclk_i);
		chk("interrupt_pin_one_o", 16'h1, 16'({interrupt_pin_zero_o, interrupt_pin_one_o}));
		wr(`OFS_SHORT_THR_LO, 8'hA1);
		wr(`OFS_SHORT_CTRL, 8'h80);
		gw(300, 6'h00);
		chk("short_power_error_o", 16'h1, 16'(short_power_error_o));
		rd(`OFS_SHORT_PWR_LO, 8'hA2);
		wr(`OFS_SHORT_CTRL, 8'h00);
		wr(`OFS_ON_ENABLE, 8'hC0);
		gw(300, 6'h20);
		main_interp_i <= 4'h2;
		wr(`OFS_LONG_THR_LO, 8'hA1);
		wr(`OFS_LONG_THR_HI, 8'h00);
		wr(`OFS_LONG_CTRL, 8'h80);
		gw(4500, 6'h00);
		chk("long_power_error_o", 16'h1, 16'(long_power_error_o));
		rd(`OFS_LONG_PWR_LO, 8'hA2);
		wr(`OFS_LONG_THR_HI, 8'h1F);
		wr(`OFS_LONG_THR_LO, 8'hFF);
		gw(4500, 6'h20);
		chk("long_power_error_o", 16'h0, 16'(long_power_error_o));
		wr(`OFS_LONG_CTRL, 8'h00);
		repeat (4) @(posedge mclk_i);
		end_sim();
	end
endmodule

// file: verilog/soft_off_power_protect.sv
// soft off / soft on gain ramp and average power protection for one main DAC path
// assumes samples, pins and register strobes are synchronous to mclk_i; page select comes from outside
// assumes the rotation arm arrives as a level from its own register elsewhere in the device
//
// Operation
// - link interrupts go to pin zero when route bit is 0, pin one when 1
// - no gain ramping at all unless gain ramp master enable bit 7 is set
// - short window power error starts soft off when bit 7 set, resets 1
// - long window power error starts soft off when bit 6 set, resets 1
// - link receiver error starts soft off when bit 3 set, resets 0
// - sync rotation starts soft off when bit 2 and rotation arm both high
// - falling edge of transmit enable pin starts soft off when bit 1 set
// - writing bit 0 of soft off enable forces ramp down if gain is unity
// - writing bit 7 of soft on enable forces ramp up if gain is zero
// - bit 6 of soft on enable allows long window level soft on
// - 13-bit long threshold in low byte and 5-bit high part, compared to average
// - long average and error detection run only while long enable bit set
// - long window averages over 2^(9+code) PA clock periods
// - PA period 4*main interp, else 8*main when channel interp, else 32
// - power is I^2+Q^2 of six top bits; long average readable
// - register accesses apply only to the path chosen by page select
// - short average and error detection run only while short enable set
// - short window averages over 2^code PA clock periods
`timescale 1ns/1ps
`include "soft_off_consts.svh"

module soft_off_power_protect
	import soft_off_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_write_i,
	input  wire logic        reg_read_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        main_path_page_select_i,
	input  wire logic [3:0]  main_interp_i,
	input  wire logic [3:0]  chan_interp_i,
	input  wire iq_t         sample_i,
	output iq_t              sample_o,
	output logic      [5:0]  gain_o,
	input  wire logic        transmit_enable_pin_i,
	input  wire logic        link_error_i,
	input  wire logic        sync_rotation_i,
	input  wire logic        sync_rotation_arm_i,
	input  wire logic        link_irq_i,
	output logic             interrupt_pin_zero_o,
	output logic             interrupt_pin_one_o,
	output logic             short_power_error_o,
	output logic             long_power_error_o
);

	state_t q;
	state_t d;

	// ============================================================
	// register access decode
	// ============================================================

	logic        wr;
	logic        rd;
	logic [8:0]  pa_period;
	logic        pa_tick;
	logic [12:0] power;
	logic signed [5:0]  i_top;
	logic signed [5:0]  q_top;
	logic signed [11:0] i_sq;
	logic signed [11:0] q_sq;

	// the page select is a plain level from outside; this block keeps no page of its own
	// accesses from another page belong to another path
	assign wr = reg_write_i & main_path_page_select_i;
	assign rd = reg_read_i & main_path_page_select_i;

	// ============================================================
	// PA clock tick and sample power
	// ============================================================

	// main interpolation wins over channel interpolation when both exceed one
	// a main factor of zero with channel interpolation gives no usable period; software must avoid it
	always_comb begin
		if (main_interp_i > 4'h1) begin
			pa_period = 9'(`PA_MULT_MAIN * main_interp_i);
		end else if (chan_interp_i > 4'h1) begin
			pa_period = 9'(`PA_MULT_CHAN * main_interp_i);
		end else begin
			pa_period = `PA_PERIOD_PLAIN;
		end
	end

	// compare against period minus one, so a tick lands every period clocks
	// greater-or-equal lets a period shortened mid-count tick at once instead of wrapping
	assign pa_tick = (q.pa_cnt >= pa_period - 9'h001);

	// only the six top bits of each sample enter the power figure
	assign i_top = $signed(sample_i.i[15:16-`SAMPLE_KEEP_BITS]);
	assign q_top = $signed(sample_i.q[15:16-`SAMPLE_KEEP_BITS]);
	assign i_sq  = i_top * i_top;
	assign q_sq  = q_top * q_top;
	// squares are never negative, so the zero bit added on top hides no sign
	assign power = {1'b0, i_sq} + {1'b0, q_sq};

	// ============================================================
	// averaging window, shared by long and short meters
	// ============================================================

	// accumulates one power figure per PA tick; shift gives the window length
	function automatic meter_t meter_step(
		input meter_t      m,
		input logic        en,
		input logic        tick,
		input logic [4:0]  shift,
		input logic [12:0] thr,
		input logic [12:0] pwr
	);
		meter_t      n;
		logic [24:0] limit;
		logic [35:0] sum;
		n      = m;
		limit  = 25'h1 << shift;
		// 36 bits hold 2^24 ticks of the largest power figure without overflow
		sum    = m.acc + {23'h0, pwr};
		n.done = 1'b0;
		if (!en) begin
			// a disabled window keeps no history and raises no error
			n.count = 25'h0;
			n.acc   = 36'h0;
			n.err   = 1'b0;
		end else if (tick) begin
			// the window closes on its last tick, so the sum already holds that tick
			if (m.count == limit - 25'h1) begin
				n.avg   = 13'(sum >> shift);
				n.err   = (13'(sum >> shift) > thr);
				n.done  = 1'b1;
				n.count = 25'h0;
				n.acc   = 36'h0;
			end else begin
				n.count = m.count + 25'h1;
				n.acc   = sum;
			end
		end
		return n;
	endfunction

	// ============================================================
	// next state
	// ============================================================

	logic        ramp_en;
	logic        off_cmd;
	logic        on_cmd;
	logic        off_trig;
	logic        on_trig;
	logic        txen_fall;
	logic [10:0] step_len;
	logic signed [22:0] i_prod;
	logic signed [22:0] q_prod;

	assign ramp_en   = q.gain_ctrl[`BIT_RAMP_MASTER_EN];
	assign txen_fall = q.txen_prev & ~transmit_enable_pin_i;
	// a force command is a write of one; it does nothing unless gain sits at its end
	assign off_cmd   = wr && reg_addr_i == `OFS_OFF_ENABLE && reg_wdata_i[`BIT_OFF_SOFTWARE];
	assign on_cmd    = wr && reg_addr_i == `OFS_ON_ENABLE && reg_wdata_i[`BIT_ON_SOFTWARE];
	// 32 steps over 2^(code+8) clocks gives 2^(code+3) clocks per step
	// shift amount widened to four bits so rate codes above four do not wrap
	assign step_len  = 11'h1 << ({1'b0, q.gain_ctrl[2:0]} + 4'(`RAMP_STEP_SHIFT));

	// each source is gated by its own enable; several may fire together and merge into one
	// power errors count only in the cycle a window closes, not while the flag stands
	always_comb begin
		off_trig = off_cmd;
		if (q.off_en[`BIT_OFF_SHORT_ERR] && q.short_m.done && q.short_m.err) begin
			off_trig = 1'b1;
		end
		if (q.off_en[`BIT_OFF_LONG_ERR] && q.long_m.done && q.long_m.err) begin
			off_trig = 1'b1;
		end
		if (q.off_en[`BIT_OFF_LINK_ERR] && link_error_i) begin
			off_trig = 1'b1;
		end
		if (q.off_en[`BIT_OFF_ROTATION] && sync_rotation_arm_i && sync_rotation_i) begin
			off_trig = 1'b1;
		end
		if (q.off_en[`BIT_OFF_TXEN_FALL] && txen_fall) begin
			off_trig = 1'b1;
		end
	end

	// level soft on: a finished long window that came in at or under the limit
	assign on_trig = on_cmd
		| (q.on_en[`BIT_ON_LONG_LEVEL] && q.long_m.done && !q.long_m.err);

	// full-width products; a 16-bit product would lose the top bits before the shift
	assign i_prod = $signed(sample_i.i) * $signed({1'b0, q.gain});
	assign q_prod = $signed(sample_i.q) * $signed({1'b0, q.gain});

	always_comb begin
		d = q;
		d.txen_prev = transmit_enable_pin_i;

		// register writes
		// read-only and unmapped addresses fall to the default and change nothing
		// reserved bits outside soft on enable are masked on the way in so they read back as zero
		if (wr) begin
			unique case (reg_addr_i)
				`OFS_LINK_IRQ_ROUTE: d.irq_sel = reg_wdata_i[`BIT_LINK_IRQ_SEL];
				`OFS_GAIN_CTRL:      d.gain_ctrl = reg_wdata_i & 8'h87;
				`OFS_OFF_ENABLE:     d.off_en = reg_wdata_i & 8'hCF;
				`OFS_ON_ENABLE:      d.on_en = reg_wdata_i;
				`OFS_LONG_THR_LO:    d.long_thr[7:0] = reg_wdata_i;
				`OFS_LONG_THR_HI:    d.long_thr[12:8] = reg_wdata_i[4:0];
				`OFS_LONG_CTRL:      d.long_ctrl = reg_wdata_i & 8'h8F;
				`OFS_SHORT_THR_LO:   d.short_thr[7:0] = reg_wdata_i;
				`OFS_SHORT_THR_HI:   d.short_thr[12:8] = reg_wdata_i[4:0];
				`OFS_SHORT_CTRL:     d.short_ctrl = reg_wdata_i & 8'h83;
				default:             d.rdata = q.rdata;
			endcase
		end

		// register reads, answered one clock after the strobe
		// a read and a write in the same cycle see the value held before that write
		if (rd) begin
			unique case (reg_addr_i)
				`OFS_LINK_IRQ_ROUTE: d.rdata = {7'h0, q.irq_sel};
				`OFS_GAIN_CTRL:      d.rdata = q.gain_ctrl;
				`OFS_OFF_ENABLE:     d.rdata = q.off_en;
				`OFS_ON_ENABLE:      d.rdata = q.on_en;
				`OFS_LONG_THR_LO:    d.rdata = q.long_thr[7:0];
				`OFS_LONG_THR_HI:    d.rdata = {3'h0, q.long_thr[12:8]};
				`OFS_LONG_CTRL:      d.rdata = q.long_ctrl;
				`OFS_LONG_PWR_LO:    d.rdata = q.long_m.avg[7:0];
				`OFS_LONG_PWR_HI:    d.rdata = {3'h0, q.long_m.avg[12:8]};
				`OFS_SHORT_THR_LO:   d.rdata = q.short_thr[7:0];
				`OFS_SHORT_THR_HI:   d.rdata = {3'h0, q.short_thr[12:8]};
				`OFS_SHORT_CTRL:     d.rdata = q.short_ctrl;
				`OFS_SHORT_PWR_LO:   d.rdata = q.short_m.avg[7:0];
				`OFS_SHORT_PWR_HI:   d.rdata = {3'h0, q.short_m.avg[12:8]};
				default:             d.rdata = 8'h00;
			endcase
		end

		// PA clock divider
		d.pa_cnt = pa_tick ? 9'h000 : q.pa_cnt + 9'h001;

		// both meters sample the same power figure on the PA tick
		d.long_m = meter_step(q.long_m, q.long_ctrl[`BIT_METER_EN], pa_tick,
			5'(`LONG_BASE_SHIFT) + {1'b0, q.long_ctrl[3:0]}, q.long_thr, power);
		d.short_m = meter_step(q.short_m, q.short_ctrl[`BIT_METER_EN], pa_tick,
			{3'h0, q.short_ctrl[1:0]}, q.short_thr, power);

		// gain ramp sequencer
		if (!ramp_en) begin
			// without the master enable the path runs at unity and ignores triggers
			d.gstate   = GAIN_UNITY;
			d.gain     = `RAMP_STEPS;
			d.step_cnt = 11'h000;
		end else begin
			unique case (q.gstate)
				GAIN_UNITY: begin
					d.step_cnt = 11'h000;
					if (off_trig) begin
						d.gstate = GAIN_DOWN;
					end
				end
				GAIN_DOWN: begin
					// triggers seen mid-ramp are dropped; the ramp runs to its end unless the master enable is cleared
					// the step counter restarts each step but is compared against the current rate, so a rate change also moves the end of the step in progress
					if (q.step_cnt == step_len - 11'h001) begin
						d.step_cnt = 11'h000;
						d.gain     = q.gain - 6'h01;
						if (q.gain == 6'h01) begin
							d.gstate = GAIN_ZERO;
						end
					end else begin
						d.step_cnt = q.step_cnt + 11'h001;
					end
				end
				GAIN_ZERO: begin
					// further ramp down requests mean nothing once gain is zero
					d.step_cnt = 11'h000;
					if (on_trig) begin
						d.gstate = GAIN_UP;
					end
				end
				GAIN_UP: begin
					// the last step lands on 32, exact unity at the output
					if (q.step_cnt == step_len - 11'h001) begin
						d.step_cnt = 11'h000;
						d.gain     = q.gain + 6'h01;
						if (q.gain == `RAMP_STEPS - 6'h01) begin
							d.gstate = GAIN_UNITY;
						end
					end else begin
						d.step_cnt = q.step_cnt + 11'h001;
					end
				end
			endcase
		end

		// scaled output; gain of 32 is exact unity once five fraction bits are dropped
		d.out.i = i_prod[20:5];
		d.out.q = q_prod[20:5];

		// link interrupt steering
		// the route bit is read before this cycle's write, so a new route shows one clock late
		d.interrupt_pin_zero = link_irq_i & ~q.irq_sel;
		d.interrupt_pin_one = link_irq_i & q.irq_sel;

		// reset is synchronous and folded in last, so it wins over everything above
		// pin memory clears low so a pin held low across reset gives no false edge
		if (reset_i) begin
			d            = '0;
			d.off_en     = `RST_OFF_ENABLE;
			d.on_en      = `RST_ON_ENABLE;
			d.gstate     = GAIN_UNITY;
			d.gain       = `RAMP_STEPS;
			d.txen_prev  = 1'b0;
		end
	end

	// ============================================================
	// state register and outputs
	// ============================================================

	// single register for all state; reset is folded into the next value
	always_ff @(posedge mclk_i) begin
		q <= d;
	end

	assign reg_rdata_o          = q.rdata;
	assign sample_o             = q.out;
	assign gain_o               = q.gain;
	assign interrupt_pin_zero_o = q.interrupt_pin_zero;
	assign interrupt_pin_one_o  = q.interrupt_pin_one;
	// error flags stand until the next window end or until the meter is switched off
	assign short_power_error_o  = q.short_m.err;
	assign long_power_error_o   = q.long_m.err;

endmodule
